/* File: design/dgci_serial_port.sv */
// Serial side of the gain register, clocked by the host serial clock.
// Assumes the clock stands still outside frames; select high ends a frame.
module dgci_serial_port (
  input wire logic sclk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  input wire logic mode_pin,
  output logic [dgci_pkg::REG_W-1:0] shift_reg,
  output logic update_toggle,
  output logic serial_data_out,
  output logic serial_data_oe_n
);
  import dgci_pkg::*;

  logic frame_rst_n;
  dgci_phase_t phase_ff, nxt_phase;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] reg_ff, nxt_reg;
  logic tgl_ff, nxt_tgl;
  logic mode_meta_ff, mode_ff, nxt_mode_meta, nxt_mode;
  logic sdo_ff, nxt_sdo, oe_n_ff, nxt_oe_n;
  logic [7:0] byte_in;

  // Select high clears the frame at once, so a torn frame never commits
  assign frame_rst_n = reset_n & ~chip_select_n;
  assign byte_in = {sh_ff[6:0], serial_data_in};

  // ***************************************************
  // Frame counter and shifter, rising edge
  // ***************************************************
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff + 3'h1;
    nxt_sh = byte_in;
    if (cnt_ff == BIT_LAST) begin
      if (phase_ff == DGCI_PH_READ) begin
        nxt_phase = DGCI_PH_WRITE;
      end else if (byte_in[RW_POS] == RW_READ) begin
        nxt_phase = DGCI_PH_READ;
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_ff <= DGCI_PH_WRITE;
      cnt_ff <= BIT_FIRST;
      sh_ff <= REG_RST;
    end else begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
    end
  end

  // ***************************************************
  // Stored register and mode sync, rising edge
  // ***************************************************
  always_comb begin
    nxt_mode_meta = mode_pin;
    nxt_mode = mode_meta_ff;
    nxt_reg = reg_ff;
    nxt_tgl = tgl_ff;
    // Eighth bit of a write frame commits; parallel mode never does
    if (!chip_select_n && phase_ff == DGCI_PH_WRITE &&
        cnt_ff == BIT_LAST && byte_in[RW_POS] == RW_WRITE &&
        mode_ff != MODE_PARALLEL) begin
      nxt_reg = byte_in;
      nxt_tgl = ~tgl_ff;
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_meta_ff <= MODE_PARALLEL;
      mode_ff <= MODE_PARALLEL;
      reg_ff <= REG_RST;
      tgl_ff <= 1'b0;
    end else begin
      mode_meta_ff <= nxt_mode_meta;
      mode_ff <= nxt_mode;
      reg_ff <= nxt_reg;
      tgl_ff <= nxt_tgl;
    end
  end

  // ***************************************************
  // Read-back driver, falling edge
  // ***************************************************
  always_comb begin
    nxt_sdo = 1'b0;
    nxt_oe_n = 1'b1;
    if (phase_ff == DGCI_PH_READ && mode_ff != MODE_PARALLEL) begin
      nxt_sdo = reg_ff[BIT_LAST - cnt_ff];
      nxt_oe_n = 1'b0;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      sdo_ff <= nxt_sdo;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign shift_reg = reg_ff;
  assign update_toggle = tgl_ff;
  assign serial_data_out = sdo_ff;
  assign serial_data_oe_n = oe_n_ff;

  // ***************************************************
  // Checks
  // ***************************************************
  a_read_drive: assert property (@(posedge sclk)
    disable iff (!frame_rst_n)
    phase_ff == DGCI_PH_READ && mode_ff != MODE_PARALLEL
    |-> !oe_n_ff && sdo_ff == reg_ff[BIT_LAST - cnt_ff])
    else $error("read bit not driven");
  // Seen at the next serial clock, often in the following frame, so the
  // select rising between frames must not cancel the check
  a_write_commit: assert property (@(posedge sclk)
    disable iff (!reset_n)
    phase_ff == DGCI_PH_WRITE && cnt_ff == BIT_LAST &&
    byte_in[RW_POS] == RW_WRITE && mode_ff != MODE_PARALLEL
    |=> tgl_ff != $past(tgl_ff) && reg_ff == $past(byte_in))
    else $error("write frame not committed");
  c_read_frame: cover property (@(posedge sclk)
    disable iff (!frame_rst_n)
    phase_ff == DGCI_PH_READ && cnt_ff == BIT_LAST);
endmodule

/* File: design/dgci_top.sv */
// Digital gain control front end: picks the gain path, applies fast
// attack and power controls. Assumes pins are asynchronous to clk.
module dgci_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mode_select,
  input wire logic gain_bit4_or_serial_clock,
  input wire logic gain_bit3_or_chip_select,
  input wire logic gain_bit2_or_attack_trigger,
  input wire logic gain_bit_one,
  input wire logic gain_bit_zero,
  input wire logic capture_hold,
  input wire logic power_select,
  input wire logic power_up_input,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_n,
  output logic [dgci_pkg::GAIN_W-1:0] applied_gain_code,
  output logic signed [5:0] applied_gain_db,
  output logic low_power_mode,
  output logic device_powered,
  output logic parallel_active
);
  import dgci_pkg::*;

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [SP_W-1:0] pin_meta_ff;
  logic [SP_W-1:0] pin_sync_ff;
  logic [SP_W-1:0] nxt_pin_meta;
  logic [SP_W-1:0] nxt_pin_sync;
  logic tgl_meta_ff;
  logic tgl_sync_ff;
  logic tgl_seen_ff;
  logic nxt_tgl_meta;
  logic nxt_tgl_sync;
  logic nxt_tgl_seen;
  logic [REG_W-1:0] link_reg;
  logic link_tgl;
  logic [GAIN_W-1:0] held_ff;
  logic [GAIN_W-1:0] nxt_held;
  logic [REG_W-1:0] ser_reg_ff;
  logic [REG_W-1:0] nxt_ser_reg;
  logic [GAIN_W-1:0] gain_code_ff;
  logic [GAIN_W-1:0] nxt_gain_code;
  logic signed [5:0] gain_db_ff;
  logic signed [5:0] nxt_gain_db;
  logic low_power_ff;
  logic nxt_low_power;
  logic powered_ff;
  logic nxt_powered;
  logic par_mode_ff;
  logic nxt_par_mode;
  logic par_s;
  logic latch_s;
  logic fa_s;
  logic psel_s;
  logic pwr_up_s;
  logic hold_now;
  logic upd_pulse;
  logic [GAIN_W-1:0] pin_code;
  logic [GAIN_W-1:0] par_code;
  logic [GAIN_W-1:0] ser_code;
  logic [1:0] fa_field;
  logic [GAIN_W-1:0] step_s;
  logic [5:0] attack_sum;

  // ***************************************************
  // Helpers
  // ***************************************************
  // Anything past the bottom of the table lands on the bottom entry
  function automatic logic [GAIN_W-1:0] clamp_code(input logic [5:0] v);
    logic [GAIN_W-1:0] r;
    r = GAIN_MIN_CODE;
    if (v <= {1'b0, GAIN_MIN_CODE}) begin
      r = v[GAIN_W-1:0];
    end
    return r;
  endfunction

  function automatic logic [GAIN_W-1:0] step_of(input logic [1:0] fa);
    logic [GAIN_W-1:0] r;
    r = STEP_8DB;
    case (fa)
      FA_1DB: r = STEP_1DB;
      FA_2DB: r = STEP_2DB;
      FA_4DB: r = STEP_4DB;
      default: r = STEP_8DB;
    endcase
    return r;
  endfunction

  // ***************************************************
  // Serial link, on the host serial clock
  // ***************************************************
  // The shared bit 3 pin is the chip select in serial mode
  dgci_serial_port u_serial (
    .sclk(gain_bit4_or_serial_clock),
    .reset_n(reset_n),
    .chip_select_n(gain_bit3_or_chip_select),
    .serial_data_in(serial_data_in),
    .mode_pin(mode_select),
    .shift_reg(link_reg),
    .update_toggle(link_tgl),
    .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n)
  );

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  // The serial clock pin is also parallel bit 4, so it is sampled here
  always_comb begin
    nxt_pin_meta = {mode_select,
                    gain_bit4_or_serial_clock,
                    gain_bit3_or_chip_select,
                    gain_bit2_or_attack_trigger,
                    gain_bit_one,
                    gain_bit_zero,
                    capture_hold,
                    power_select,
                    power_up_input};
    nxt_pin_sync = pin_meta_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_ff <= SP_RST;
      pin_sync_ff <= SP_RST;
    end else begin
      pin_meta_ff <= nxt_pin_meta;
      pin_sync_ff <= nxt_pin_sync;
    end
  end

  // ***************************************************
  // Register update crossing
  // ***************************************************
  // The link holds its register for at least eight serial clocks after
  // each toggle, far longer than this three-flop path needs
  always_comb begin
    nxt_tgl_meta = link_tgl;
    nxt_tgl_sync = tgl_meta_ff;
    nxt_tgl_seen = tgl_sync_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_meta_ff <= 1'b0;
      tgl_sync_ff <= 1'b0;
      tgl_seen_ff <= 1'b0;
    end else begin
      tgl_meta_ff <= nxt_tgl_meta;
      tgl_sync_ff <= nxt_tgl_sync;
      tgl_seen_ff <= nxt_tgl_seen;
    end
  end

  assign upd_pulse = tgl_sync_ff ^ tgl_seen_ff;

  // ***************************************************
  // Decoded pin levels
  // ***************************************************
  assign par_s = (pin_sync_ff[SP_MODE] == MODE_PARALLEL);
  assign latch_s = (pin_sync_ff[SP_LATCH] == LATCH_HOLD);
  assign pin_code = pin_sync_ff[SP_G4:SP_G0];
  assign fa_s = pin_sync_ff[SP_G2] & ~par_s;
  assign psel_s = pin_sync_ff[SP_PSEL];
  assign pwr_up_s = pin_sync_ff[SP_PWR_UP];
  assign hold_now = par_s & latch_s;
  assign ser_code = ser_reg_ff[GAIN_MSB:GAIN_LSB];
  assign fa_field = ser_reg_ff[FA_MSB:FA_LSB];
  assign step_s = step_of(fa_field);
  assign attack_sum = {1'b0, ser_code} + {1'b0, step_s};

  // ***************************************************
  // Gain selection
  // ***************************************************
  always_comb begin
    nxt_held = held_ff;
    nxt_ser_reg = ser_reg_ff;
    if (par_s && !latch_s) begin
      nxt_held = pin_code;
    end
    if (upd_pulse) begin
      nxt_ser_reg = link_reg;
    end
    // Latched capture keeps the value seen before the latch rose
    par_code = latch_s ? held_ff : pin_code;
    if (par_s) begin
      nxt_gain_code = clamp_code({1'b0, par_code});
    end else if (fa_s) begin
      nxt_gain_code = clamp_code(attack_sum);
    end else begin
      nxt_gain_code = clamp_code({1'b0, ser_code});
    end
    nxt_gain_db = GAIN_TOP_DB - $signed({1'b0, nxt_gain_code});
    nxt_low_power = psel_s;
    nxt_powered = pwr_up_s;
    nxt_par_mode = par_s;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      held_ff <= GAIN_MIN_CODE;
      ser_reg_ff <= REG_RST;
      gain_code_ff <= GAIN_MIN_CODE;
      gain_db_ff <= GAIN_TOP_DB - $signed({1'b0, GAIN_MIN_CODE});
      low_power_ff <= 1'b0;
      powered_ff <= 1'b0;
      par_mode_ff <= 1'b0;
    end else begin
      held_ff <= nxt_held;
      ser_reg_ff <= nxt_ser_reg;
      gain_code_ff <= nxt_gain_code;
      gain_db_ff <= nxt_gain_db;
      low_power_ff <= nxt_low_power;
      powered_ff <= nxt_powered;
      par_mode_ff <= nxt_par_mode;
    end
  end

  assign applied_gain_code = gain_code_ff;
  assign applied_gain_db = gain_db_ff;
  assign low_power_mode = low_power_ff;
  assign device_powered = powered_ff;
  assign parallel_active = par_mode_ff;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_mode_flag: assert property (
    ##1 parallel_active == $past(par_s))
    else $error("path flag does not follow select");

  a_transparent_follow: assert property (
    par_s && !latch_s
    |=> gain_code_ff == clamp_code({1'b0, $past(pin_code)}))
    else $error("transparent gain did not follow pins");

  a_latched_hold: assert property (
    hold_now && $past(hold_now)
    |=> gain_code_ff == $past(gain_code_ff))
    else $error("latched gain moved");

  a_attack_drop: assert property (
    !par_s && fa_s && $past(fa_s) == 1'b0 && $past(par_s) == 1'b0 &&
    $stable(ser_reg_ff)
    |=> gain_code_ff == clamp_code({1'b0, $past(gain_code_ff)} +
                                   {1'b0, $past(step_s)}))
    else $error("attack step not applied");

  a_attack_serial: assert property (
    par_s && pin_sync_ff[SP_G2] && !latch_s
    |=> gain_code_ff == clamp_code({1'b0, $past(pin_code)}))
    else $error("attack active in parallel mode");

  a_step_table: assert property (
    fa_field == FA_4DB |-> step_s == STEP_4DB ##0
    (fa_field != FA_1DB || step_s == STEP_1DB))
    else $error("step size decode wrong");

  a_clamp_min: assert property (
    gain_code_ff <= GAIN_MIN_CODE)
    else $error("gain code beyond minimum gain");

  a_db_map: assert property (
    gain_db_ff == GAIN_TOP_DB - $signed({1'b0, gain_code_ff}))
    else $error("gain in dB does not match code");

  a_power_mode: assert property (
    $changed(psel_s) |=> low_power_mode == $past(psel_s) ##1
    low_power_mode == $past(psel_s))
    else $error("power select not applied");

  a_power_up: assert property (
    $fell(pwr_up_s) |=> !device_powered)
    else $error("power down not applied");

  a_serial_load: assert property (
    upd_pulse |=> ser_reg_ff == $past(link_reg))
    else $error("serial register not loaded");

  c_latched: cover property (hold_now [*3]);
  c_attack: cover property (!par_s && fa_s ##1 gain_code_ff == GAIN_MIN_CODE);
  c_serial_update: cover property (upd_pulse ##1 !par_s);
endmodule

/* File: pkg/dgci_pkg.sv */
// Constants and types shared by the digital gain control front end.
// Assumes a 40 MHz system clock and a host-driven serial clock.
// Summary of operation
// - Interface select high picks parallel gain path, low picks serial.
// - Shared pins act as gain bits 4..2 or serial clock, select, attack.
// - Parallel mode takes five binary gain bits plus a capture input.
// - Transparent capture makes applied gain follow the parallel bits.
// - Latched capture holds the gain and ignores parallel bit changes.
// - Capture input low is transparent, high is latched.
// - Serial port uses data line, serial clock and active-low select.
// - Serial register is 8 bits: read/write, two step bits, five gain bits.
// - Read bit high shifts register out for eight clocks, then back to write.
// - Fast attack lowers gain by a preset step, serial mode only.
// - Step bits 00, 01, 10, 11 give 1, 2, 4, 8 dB.
// - Attack trigger high in serial mode applies the selected step.
// - Gain code 00000 is 15 dB, each step 1 dB less, 10101 is -6 dB.
// - Power select high is low power, low is high performance.
// - One power-up input serves both interface modes.
// - Power-up input high powers up, low powers down.
package dgci_pkg;
  // ***************************************************
  // Register layout
  // ***************************************************
  localparam int GAIN_W = 5;
  localparam int REG_W = 8;
  localparam int RW_POS = 7;
  localparam int FA_MSB = 6;
  localparam int FA_LSB = 5;
  localparam int GAIN_MSB = 4;
  localparam int GAIN_LSB = 0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  // Reset leaves the amplifier at its lowest gain
  localparam logic [7:0] REG_RST = 8'h15;
  localparam logic [4:0] GAIN_MIN_CODE = 5'h15;
  localparam logic signed [5:0] GAIN_TOP_DB = 6'sh0F;
  // ***************************************************
  // Attack steps, in gain code units of 1 dB
  // ***************************************************
  localparam logic [1:0] FA_1DB = 2'h0;
  localparam logic [1:0] FA_2DB = 2'h1;
  localparam logic [1:0] FA_4DB = 2'h2;
  localparam logic [4:0] STEP_1DB = 5'h01;
  localparam logic [4:0] STEP_2DB = 5'h02;
  localparam logic [4:0] STEP_4DB = 5'h04;
  localparam logic [4:0] STEP_8DB = 5'h08;
  // ***************************************************
  // Pin levels and serial framing
  // ***************************************************
  localparam logic MODE_PARALLEL = 1'b1;
  localparam logic LATCH_HOLD = 1'b1;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  // Synchronised pin vector positions
  localparam int SP_MODE = 8;
  localparam int SP_G4 = 7;
  localparam int SP_G2 = 5;
  localparam int SP_G0 = 3;
  localparam int SP_LATCH = 2;
  localparam int SP_PSEL = 1;
  localparam int SP_PWR_UP = 0;
  localparam int SP_W = 9;
  localparam logic [8:0] SP_RST = 9'h000;
  typedef enum logic [1:0] {
    DGCI_PH_WRITE = 2'b00,
    DGCI_PH_READ = 2'b01
  } dgci_phase_t;
endpackage

/* File: test/dgci_host_model.sv */
// Host controller model driving the gain pins, parallel or serial.
// Assumes the bench resolves the shared data wire and feeds it back.
module dgci_host_model (
  input wire logic clk,
  input wire logic sdio,
  output logic mode_select,
  output logic g4_sclk,
  output logic g3_cs_n,
  output logic g2_fa,
  output logic g1,
  output logic g0,
  output logic capture_hold,
  output logic power_select,
  output logic power_up_input,
  output logic host_sd
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mode_select = 1'b1;
    {g4_sclk, g3_cs_n, g2_fa, g1, g0} = 5'h00;
    capture_hold = 1'b0;
    power_select = 1'b0;
    power_up_input = 1'b0;
    host_sd = 1'b0;
  end

  // ***************************************************
  // Parallel and level pins, moved on the falling clk edge
  // ***************************************************
  task automatic set_par(input logic [4:0] code, input logic hold);
    @(negedge clk);
    {g4_sclk, g3_cs_n, g2_fa, g1, g0} = code;
    capture_hold = hold;
  endtask

  task automatic set_pwr(input logic low_pwr, input logic pwr_on);
    @(negedge clk);
    power_select = low_pwr;
    power_up_input = pwr_on;
  endtask

  task automatic set_fa(input logic v);
    @(negedge clk);
    g2_fa = v;
  endtask

  // Two idle serial clocks let the device see the new mode
  task automatic set_mode(input logic m);
    @(negedge clk);
    mode_select = m;
    if (!m) begin
      g4_sclk = 1'b0;
      g3_cs_n = 1'b1;
      g2_fa = 1'b0;
      repeat (2) begin
        #24 g4_sclk = 1'b1;
        #24 g4_sclk = 1'b0;
      end
    end
  endtask

  // ***************************************************
  // Serial frame; clock stands still outside the frame
  // ***************************************************
  task automatic frame(input logic [7:0] tx, input int nbits,
                       input logic rd, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    // Keeps select high for a while when frames follow back to back
    #24 g3_cs_n = 1'b0;
    #20;
    for (i = 0; i < nbits; i++) begin
      host_sd = tx[7-i];
      #24 g4_sclk = 1'b1;
      #24 g4_sclk = 1'b0;
    end
    // Released line shows the inverse, not a stale bit
    host_sd = ~host_sd;
    if (rd) begin
      for (i = 0; i < 8; i++) begin
        #24 g4_sclk = 1'b1;
        rx = {rx[6:0], sdio};
        #24 g4_sclk = 1'b0;
        host_sd = ~host_sd;
      end
    end
    #20 g3_cs_n = 1'b1;
  endtask
endmodule

/* File: test/test_digital_gain_control_interface.sv */
// Self-checking bench for the gain control front end.
// Assumes dgci_top and dgci_host_model; serial clock period 48 ns.
module test_digital_gain_control_interface;
  timeunit 1ns;
  timeprecision 100ps;
  import dgci_pkg::*;

  typedef struct packed {
    logic [4:0] code;
    logic low_pwr;
    logic pwr_on;
    logic [4:0] exp;
  } dgci_row_t;

  localparam dgci_row_t ROWS [6] = '{
    '{5'h00, 1'b0, 1'b1, 5'h00}, '{5'h07, 1'b1, 1'b1, 5'h07},
    '{5'h0F, 1'b0, 1'b0, 5'h0F}, '{5'h15, 1'b1, 1'b0, 5'h15},
    '{5'h16, 1'b0, 1'b1, 5'h15}, '{5'h1F, 1'b1, 1'b1, 5'h15}};

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode_select, g4, g3, g2, g1, g0, capture_hold;
  logic power_select, power_up_input, host_sd;
  logic serial_data_out, serial_data_oe_n;
  logic [4:0] applied_gain_code;
  logic signed [5:0] applied_gain_db;
  logic low_power_mode, device_powered, parallel_active;
  wire sdio;
  logic [7:0] rx;
  logic [4:0] e;
  int miscompares = 0;
  int checks_done = 0;
  int i;

  always #12.5 clk = ~clk;
  assign sdio = serial_data_oe_n ? host_sd : serial_data_out;

  dgci_host_model host (
    .clk(clk), .sdio(sdio), .mode_select(mode_select), .g4_sclk(g4),
    .g3_cs_n(g3), .g2_fa(g2), .g1(g1), .g0(g0),
    .capture_hold(capture_hold), .power_select(power_select),
    .power_up_input(power_up_input), .host_sd(host_sd)
  );

  dgci_top dut (
    .clk(clk), .reset_n(reset_n), .mode_select(mode_select),
    .gain_bit4_or_serial_clock(g4), .gain_bit3_or_chip_select(g3),
    .gain_bit2_or_attack_trigger(g2), .gain_bit_one(g1),
    .gain_bit_zero(g0), .capture_hold(capture_hold),
    .power_select(power_select), .power_up_input(power_up_input),
    .serial_data_in(sdio), .serial_data_out(serial_data_out),
    .serial_data_oe_n(serial_data_oe_n),
    .applied_gain_code(applied_gain_code),
    .applied_gain_db(applied_gain_db), .low_power_mode(low_power_mode),
    .device_powered(device_powered), .parallel_active(parallel_active)
  );

  // ***************************************************
  // Comparison and closing
  // ***************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Signed, so negative gains extend the same way as the output does
  function automatic logic signed [5:0] db_of(input logic [4:0] c);
    return GAIN_TOP_DB - $signed({1'b0, c});
  endfunction

  task automatic gain_is(input logic [4:0] c);
    check(8'(applied_gain_code), 8'(c));
    check(8'(applied_gain_db), 8'(db_of(c)));
  endtask

  task automatic final_report;
    $display("miscompares %0d checks_done %0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Whole run needs about 12 us; twenty-five times that is a hang
  initial begin
    #300us;
    miscompares++;
    final_report();
  end

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    repeat (16) @(negedge clk);
    gain_is(GAIN_MIN_CODE);
    check(8'(device_powered), 8'h00);
    reset_n = 1'b1;
    for (i = 0; i < 6; i++) begin
      host.set_pwr(ROWS[i].low_pwr, ROWS[i].pwr_on);
      host.set_par(ROWS[i].code, 1'b0);
      repeat (6) @(negedge clk);
      gain_is(ROWS[i].exp);
      check(8'(low_power_mode), 8'(ROWS[i].low_pwr));
      check(8'(device_powered), 8'(ROWS[i].pwr_on));
      check(8'(parallel_active), 8'h01);
    end
    host.set_par(5'h09, 1'b0);
    host.set_par(5'h09, 1'b1);
    host.set_par(5'h02, 1'b1);
    repeat (6) @(negedge clk);
    gain_is(5'h09);
    host.set_par(5'h02, 1'b0);
    repeat (6) @(negedge clk);
    gain_is(5'h02);
    host.set_mode(1'b0);
    repeat (8) @(negedge clk);
    gain_is(GAIN_MIN_CODE);
    check(8'(parallel_active), 8'h00);
    host.frame(8'h03, 8, 1'b0, rx);
    repeat (12) @(negedge clk);
    gain_is(5'h03);
    host.frame(8'h0C, 4, 1'b0, rx);
    repeat (12) @(negedge clk);
    gain_is(5'h03);
    for (i = 0; i < 4; i++) begin
      host.frame({1'b0, 2'(i), 5'h0A}, 8, 1'b0, rx);
      repeat (12) @(negedge clk);
      host.set_fa(1'b1);
      repeat (6) @(negedge clk);
      e = 5'h0A + (5'h01 << i);
      gain_is(e);
      host.set_fa(1'b0);
      repeat (6) @(negedge clk);
      gain_is(5'h0A);
    end
    host.frame(8'h72, 8, 1'b0, rx);
    repeat (12) @(negedge clk);
    host.set_fa(1'b1);
    repeat (6) @(negedge clk);
    gain_is(GAIN_MIN_CODE);
    host.set_fa(1'b0);
    host.frame(8'h16, 8, 1'b0, rx);
    repeat (12) @(negedge clk);
    gain_is(GAIN_MIN_CODE);
    host.frame(8'h4A, 8, 1'b0, rx);
    host.frame(8'h80, 8, 1'b1, rx);
    check(rx, 8'h4A);
    check(8'(serial_data_oe_n), 8'h01);
    repeat (12) @(negedge clk);
    gain_is(5'h0A);
    host.frame(8'h05, 8, 1'b0, rx);
    repeat (12) @(negedge clk);
    gain_is(5'h05);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    gain_is(GAIN_MIN_CODE);
    check(8'(device_powered), 8'h00);
    check(8'(low_power_mode), 8'h00);
    check(8'(parallel_active), 8'h00);
    check(8'(serial_data_oe_n), 8'h01);
    final_report();
  end
endmodule
